// ### phy_status_map.svh
`ifndef PHY_STATUS_MAP_SVH
`define PHY_STATUS_MAP_SVH

// Management register offsets
`define GIG_LINK_STATUS_OFS 5'h0A
`define EXT_ACCESS_CONTROL_OFS 5'h0D
`define EXT_ADDRESS_DATA_OFS 5'h0E
`define GIG_ABILITY_EXT_OFS 5'h0F
`define FAST_LINK_STATUS_EXT_OFS 5'h10
`define GIG_LINK_STATUS_EXT_OFS 5'h11

// Gigabit status fields
`define GLS_FAULT_BIT 15
`define GLS_MASTER_BIT 14
`define GLS_LOCAL_RX_BIT 13
`define GLS_REMOTE_RX_BIT 12
`define GLS_LP_FDX_BIT 11
`define GLS_LP_HDX_BIT 10
`define GLS_MASTER_RST 1'h1
`define IDLE_CNT_RST 8'h00
`define IDLE_CNT_MAX 8'hFF
`define IDLE_CNT_ONE 8'h01
`define IDLE_CNT_HI 7
`define IDLE_CNT_LO 0
`define LEVEL_RST 1'h0

// Extended access control fields
`define EAC_FUNC_HI 15
`define EAC_FUNC_LO 14
`define EAC_DEV_HI 4
`define EAC_DEV_LO 0
`define EAC_RST 16'h0000
`define EXT_ADDR_RST 16'h0000
`define EXT_ADDR_STEP 16'h0001

// Gigabit ability fields
`define GAE_FDX_BIT 13
`define GAE_HDX_BIT 12
`define GAE_FDX_RST 1'h1
`define GAE_HDX_RST 1'h1

// Status extension fields; SX_ shared by both speeds, GX_ gigabit extension only
`define SX_LOCK_BIT 15
`define SX_LINK_BIT 12
`define SX_EVT_LO 8
`define SX_EVT_HI 11
`define SX_ERR_HI 14
`define SX_ERR_LO 13
`define SX_EVT_N 4
`define GX_CEXT_FLAG 0
`define FAST_EVT_W 6
`define GIG_EVT_W 7
`define GX_CEXT_BIT 7
`define GX_NONSTD_BIT 6
`define GX_MDIX_BIT 5

`endif

// ### phy_status_pkg.sv
package phy_status_pkg;
   // Function field of the extended access control register
   typedef enum logic [1:0] {
      FN_ADDR,
      FN_DATA,
      FN_DATA_INC_RW,
      FN_DATA_INC_W
   } ext_func_t;

   typedef logic [15:0] reg_word_t;
   typedef logic [4:0] reg_addr_t;
endpackage : phy_status_pkg

// ### sticky_bank_if.sv
`timescale 1ns/1ps
// Events in, read-clear strobe in, held flags out
interface sticky_bank_if #(parameter int W = 1);
   logic [W-1:0] evt;
   logic clr;
   logic [W-1:0] flags;
   modport owner (output evt, output clr, input flags);
   modport bank (input evt, input clr, output flags);
endinterface : sticky_bank_if

// ### sticky_bank.sv
`timescale 1ns/1ps
// Bank of latched-high flags cleared by a management read
module sticky_bank (
   input wire logic clock_i,
   input wire logic reset_i,
   sticky_bank_if.bank port
);
   ////////////////////////////////////////////////////////////////////////
   // A new event in the clearing cycle survives, so nothing is lost
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         port.flags <= '0;
      end else begin
         port.flags <= (port.flags & {$bits(port.flags){~port.clr}}) | port.evt;
      end
   end
endmodule : sticky_bank

// ### phy_status_regs.sv
// Operation
// - Gigabit status bit 15 latches high on master/slave configuration fault.
// - Gigabit status bit 14 shows resolved master (1) or slave; resets to 1.
// - Bit 13 local receiver ok, bit 12 remote receiver ok; both reset 0.
// - Bits 11/10 partner gigabit full/half duplex; bits 9:8 read 0.
// - Bits 7:0 idle error count, reset zero, cleared by reading.
// - Function field 15:14 picks address, data, data+increment, data+increment on write.
// - Control bits 4:0 select extended device; bits 13:5 plain read/write.
// - Address/data register holds address in mode 00, else moves data.
// - Ability register bits 13/12 local full/half gigabit, fixed 1, rest 0.
// - Fast status bit 15 descrambler lock, bit 12 link active; reset 0.
// - Fast status bits 14 lock error, 13 disconnect; cleared by reading.
// - Fast status bits 11..8 rx, tx, start, end delimiter errors; read-clear.
// - Gigabit extension bit 15 descrambler lock, bit 12 link active; reset 0.
// - Gigabit extension bits 14 lock error, 13 disconnect; cleared by reading.
// - Gigabit extension bits 11..8 rx, tx, start, end delimiter errors; read-clear.
// - Gigabit extension bit 7 carrier extension error; cleared by reading.
// - Gigabit extension bit 6 flags a non-standard gigabit partner.
// - Gigabit extension bit 5 flags MDI crossover error; bits 4:0 reserved.
`timescale 1ns/1ps
`include "phy_status_map.svh"

module phy_status_regs (
   input wire logic clock_i,
   input wire logic reset_i,
   // Management register port
   input wire phy_status_pkg::reg_addr_t reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire phy_status_pkg::reg_word_t reg_wdata_i,
   output phy_status_pkg::reg_word_t reg_rdata_o,
   output logic reg_rvalid_o,
   // Extended register space
   output logic [4:0] ext_device_select_o,
   output phy_status_pkg::reg_word_t ext_addr_o,
   output logic ext_rd_o,
   input wire phy_status_pkg::reg_word_t ext_rdata_i,
   output logic ext_wr_o,
   output phy_status_pkg::reg_word_t ext_wdata_o,
   // Gigabit status sources
   input wire logic ms_fault_i,
   input wire logic ms_master_i,
   input wire logic local_rx_ok_i,
   input wire logic remote_rx_ok_i,
   input wire logic lp_gig_fdx_i,
   input wire logic lp_gig_hdx_i,
   input wire logic idle_err_i,
   // Fast status sources: events lock, disconnect, rx, tx, start, end
   input wire logic fast_descr_lock_i,
   input wire logic fast_link_i,
   input wire logic [5:0] fast_evt_i,
   // Gigabit extension sources: events as fast plus carrier extension
   input wire logic gig_descr_lock_i,
   input wire logic gig_link_i,
   input wire logic [6:0] gig_evt_i,
   input wire logic nonstd_partner_i,
   input wire logic mdix_err_i
);
   import phy_status_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Register hit for a given offset
   function automatic logic hit(input reg_addr_t addr, input reg_addr_t ofs);
      return addr == ofs;
   endfunction : hit

   // Saturating step of the idle error count
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      return (v == `IDLE_CNT_MAX) ? v : v + `IDLE_CNT_ONE;
   endfunction : sat_inc

   logic wr_req;
   logic rd_req;
   // A write takes precedence when both strobes come together
   assign wr_req = reg_wr_i;
   assign rd_req = reg_rd_i & ~reg_wr_i;

   ////////////////////////////////////////////////////////////////////////
   // Gigabit status register

   logic master_r;
   logic local_rx_r;
   logic remote_rx_r;
   logic lp_fdx_r;
   logic lp_hdx_r;
   logic [7:0] idle_cnt_r;
   logic [7:0] idle_cnt_nxt;
   logic gls_rd;

   assign gls_rd = rd_req & hit(reg_addr_i, `GIG_LINK_STATUS_OFS);

   // Live role and receiver levels, registered with their reset values
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         master_r <= `GLS_MASTER_RST;
         local_rx_r <= `LEVEL_RST;
         remote_rx_r <= `LEVEL_RST;
         lp_fdx_r <= `LEVEL_RST;
         lp_hdx_r <= `LEVEL_RST;
      end else begin
         master_r <= ms_master_i;
         local_rx_r <= local_rx_ok_i;
         remote_rx_r <= remote_rx_ok_i;
         lp_fdx_r <= lp_gig_fdx_i;
         lp_hdx_r <= lp_gig_hdx_i;
      end
   end

   // Read clears the count, but an error in that cycle is kept
   always_comb begin
      if (gls_rd) begin
         idle_cnt_nxt = idle_err_i ? `IDLE_CNT_ONE : `IDLE_CNT_RST;
      end else if (idle_err_i) begin
         idle_cnt_nxt = sat_inc(idle_cnt_r);
      end else begin
         idle_cnt_nxt = idle_cnt_r;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         idle_cnt_r <= `IDLE_CNT_RST;
      end else begin
         idle_cnt_r <= idle_cnt_nxt;
      end
   end

   // Configuration fault latches high until read
   sticky_bank_if #(.W(1)) fault_if ();
   assign fault_if.evt = ms_fault_i;
   assign fault_if.clr = gls_rd;

   sticky_bank u_fault (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .port(fault_if.bank)
   );

   ////////////////////////////////////////////////////////////////////////
   // Extended register window

   reg_word_t eac_r;
   reg_word_t ext_addr_r;
   reg_word_t ext_addr_nxt;
   reg_word_t wr_addr_r;
   reg_word_t ext_wdata_r;
   logic ext_wr_r;
   ext_func_t func;
   logic win_hit;
   logic data_rd;
   logic data_wr;
   logic step;

   assign func = ext_func_t'(eac_r[`EAC_FUNC_HI:`EAC_FUNC_LO]);
   assign win_hit = hit(reg_addr_i, `EXT_ADDRESS_DATA_OFS);
   assign data_rd = rd_req & win_hit & (func != FN_ADDR);
   assign data_wr = wr_req & win_hit & (func != FN_ADDR);

   // Which data accesses step the held address
   always_comb begin
      unique case (func)
         FN_ADDR: step = 1'b0;
         FN_DATA: step = 1'b0;
         FN_DATA_INC_RW: step = data_rd | data_wr;
         FN_DATA_INC_W: step = data_wr;
      endcase
   end

   // Control register, reserved bits kept as written
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         eac_r <= `EAC_RST;
      end else if (wr_req & hit(reg_addr_i, `EXT_ACCESS_CONTROL_OFS)) begin
         eac_r <= reg_wdata_i;
      end
   end

   // Address is loaded in address mode and stepped in the two increment modes
   always_comb begin
      if (wr_req & win_hit & (func == FN_ADDR)) begin
         ext_addr_nxt = reg_wdata_i;
      end else if (step) begin
         ext_addr_nxt = ext_addr_r + `EXT_ADDR_STEP;
      end else begin
         ext_addr_nxt = ext_addr_r;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ext_addr_r <= `EXT_ADDR_RST;
      end else begin
         ext_addr_r <= ext_addr_nxt;
      end
   end

   // Writes go out one cycle later, at the address in force when issued
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ext_wr_r <= 1'b0;
         wr_addr_r <= `EXT_ADDR_RST;
         ext_wdata_r <= '0;
      end else begin
         ext_wr_r <= data_wr;
         if (data_wr) begin
            wr_addr_r <= ext_addr_r;
            ext_wdata_r <= reg_wdata_i;
         end
      end
   end

   // Reads are answered in the request cycle by the extended space
   assign ext_rd_o = data_rd;
   assign ext_wr_o = ext_wr_r;
   assign ext_wdata_o = ext_wdata_r;
   // A pending write owns the address bus for its one cycle
   assign ext_addr_o = ext_wr_r ? wr_addr_r : ext_addr_r;
   assign ext_device_select_o = eac_r[`EAC_DEV_HI:`EAC_DEV_LO];

   ////////////////////////////////////////////////////////////////////////
   // Status extension registers

   logic fast_lock_r;
   logic fast_link_r;
   logic gig_lock_r;
   logic gig_link_r;
   logic nonstd_r;
   logic mdix_r;

   // Live levels, all zero out of reset
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         fast_lock_r <= `LEVEL_RST;
         fast_link_r <= `LEVEL_RST;
         gig_lock_r <= `LEVEL_RST;
         gig_link_r <= `LEVEL_RST;
         nonstd_r <= `LEVEL_RST;
         mdix_r <= `LEVEL_RST;
      end else begin
         fast_lock_r <= fast_descr_lock_i;
         fast_link_r <= fast_link_i;
         gig_lock_r <= gig_descr_lock_i;
         gig_link_r <= gig_link_i;
         nonstd_r <= nonstd_partner_i;
         mdix_r <= mdix_err_i;
      end
   end

   // Read-clear event flags of the fast register
   sticky_bank_if #(.W(`FAST_EVT_W)) fast_if ();
   assign fast_if.evt = fast_evt_i;
   assign fast_if.clr = rd_req & hit(reg_addr_i, `FAST_LINK_STATUS_EXT_OFS);

   sticky_bank u_fast (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .port(fast_if.bank)
   );

   // Read-clear event flags of the gigabit extension register
   sticky_bank_if #(.W(`GIG_EVT_W)) gig_if ();
   assign gig_if.evt = gig_evt_i;
   assign gig_if.clr = rd_req & hit(reg_addr_i, `GIG_LINK_STATUS_EXT_OFS);

   sticky_bank u_gig (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .port(gig_if.bank)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer

   reg_word_t rdata_nxt;

   // Images show the flag values from before any clear of this read
   always_comb begin
      rdata_nxt = '0;
      if (hit(reg_addr_i, `GIG_LINK_STATUS_OFS)) begin
         rdata_nxt[`GLS_FAULT_BIT] = fault_if.flags[0];
         rdata_nxt[`GLS_MASTER_BIT] = master_r;
         rdata_nxt[`GLS_LOCAL_RX_BIT] = local_rx_r;
         rdata_nxt[`GLS_REMOTE_RX_BIT] = remote_rx_r;
         rdata_nxt[`GLS_LP_FDX_BIT] = lp_fdx_r;
         rdata_nxt[`GLS_LP_HDX_BIT] = lp_hdx_r;
         rdata_nxt[`IDLE_CNT_HI:`IDLE_CNT_LO] = idle_cnt_r;
      end else if (hit(reg_addr_i, `EXT_ACCESS_CONTROL_OFS)) begin
         rdata_nxt = eac_r;
      end else if (win_hit) begin
         rdata_nxt = (func == FN_ADDR) ? ext_addr_r : ext_rdata_i;
      end else if (hit(reg_addr_i, `GIG_ABILITY_EXT_OFS)) begin
         rdata_nxt[`GAE_FDX_BIT] = `GAE_FDX_RST;
         rdata_nxt[`GAE_HDX_BIT] = `GAE_HDX_RST;
      end else if (hit(reg_addr_i, `FAST_LINK_STATUS_EXT_OFS)) begin
         rdata_nxt[`SX_LOCK_BIT] = fast_lock_r;
         rdata_nxt[`SX_LINK_BIT] = fast_link_r;
         rdata_nxt[`SX_ERR_HI:`SX_ERR_LO] = fast_if.flags[`FAST_EVT_W-1:`SX_EVT_N];
         rdata_nxt[`SX_EVT_HI:`SX_EVT_LO] = fast_if.flags[`SX_EVT_N-1:0];
      end else if (hit(reg_addr_i, `GIG_LINK_STATUS_EXT_OFS)) begin
         rdata_nxt[`SX_LOCK_BIT] = gig_lock_r;
         rdata_nxt[`SX_LINK_BIT] = gig_link_r;
         rdata_nxt[`SX_ERR_HI:`SX_ERR_LO] = gig_if.flags[`GIG_EVT_W-1:`SX_EVT_N+1];
         rdata_nxt[`SX_EVT_HI:`SX_EVT_LO] = gig_if.flags[`SX_EVT_N:`GX_CEXT_FLAG+1];
         rdata_nxt[`GX_CEXT_BIT] = gig_if.flags[`GX_CEXT_FLAG];
         rdata_nxt[`GX_NONSTD_BIT] = nonstd_r;
         rdata_nxt[`GX_MDIX_BIT] = mdix_r;
      end
   end

   // Read data is registered; unmapped offsets read as zero
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         reg_rdata_o <= '0;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= rd_req;
         if (rd_req) begin
            reg_rdata_o <= rdata_nxt;
         end
      end
   end

endmodule : phy_status_regs

// ### phy_ext_model.sv
`timescale 1ns/1ps
// Extended register space seen through the window
module phy_ext_model (
   input wire logic clock_i,
   input wire logic [15:0] ext_addr_i,
   input wire logic ext_rd_i,
   input wire logic ext_wr_i,
   input wire logic [15:0] ext_wdata_i,
   output logic [15:0] ext_rdata_o
);
   logic [15:0] mem [0:15] = '{default: 16'h0000};
   logic [15:0] last_r = 16'h0000;
   // Store on write strobe
   always_ff @(posedge clock_i) begin
      if (ext_wr_i) begin
         mem[ext_addr_i[3:0]] <= ext_wdata_i;
      end
      if (ext_rd_i) begin
         last_r <= mem[ext_addr_i[3:0]];
      end
   end
   // Undriven data shows junk so stale values never match
   assign ext_rdata_o = ext_rd_i ? mem[ext_addr_i[3:0]] : ~last_r;
endmodule : phy_ext_model

// ### phy_status_regs_chk.sv
`timescale 1ns/1ps
module phy_status_regs_chk (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire phy_status_pkg::reg_addr_t reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire phy_status_pkg::reg_word_t reg_wdata_i,
   input wire phy_status_pkg::reg_word_t reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic [4:0] ext_device_select_o,
   input wire logic ext_rd_o,
   input wire logic ext_wr_o,
   input wire phy_status_pkg::reg_word_t ext_wdata_o,
   input wire logic ms_master_i,
   input wire logic ms_fault_i
);
   import phy_status_pkg::*;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   logic rd_q;
   logic [4:0] wdev;
   // Write wins when both strobes are up
   assign rd_q = reg_rd_i && !reg_wr_i;
   assign wdev = reg_wdata_i[4:0];
   ////////////////////////////////////////////////////////////
   a_read_gives_valid: assert property (rd_q |=> reg_rvalid_o)
      else $error("read without valid");
   a_valid_needs_read: assert property (reg_rvalid_o |-> $past(rd_q))
      else $error("valid without read");
   a_ability_fixed: assert property (rd_q && reg_addr_i == 5'h0F |=> reg_rdata_o == 16'h3000)
      else $error("ability word wrong");
   a_gls_reserved_zero: assert property (rd_q && reg_addr_i == 5'h0A |=> reg_rdata_o[9:8] == 2'h0)
      else $error("reserved status bits set");
   a_fast_low_zero: assert property (rd_q && reg_addr_i == 5'h10 |=> reg_rdata_o[7:0] == 8'h00)
      else $error("fast low byte set");
   a_gx_low_zero: assert property (rd_q && reg_addr_i == 5'h11 |=> reg_rdata_o[4:0] == 5'h00)
      else $error("gigabit reserved bits set");
   a_ext_rd_cause: assert property (ext_rd_o |-> rd_q && reg_addr_i == 5'h0E)
      else $error("stray extended read");
   a_ext_wr_cause: assert property (ext_wr_o |-> $past(reg_wr_i) && $past(reg_addr_i) == 5'h0E
      && ext_wdata_o == $past(reg_wdata_i))
      else $error("stray extended write");
   a_dev_sel_write: assert property (reg_wr_i && reg_addr_i == 5'h0D |=> ext_device_select_o == $past(wdev))
      else $error("device select not updated");
   a_fault_latched: assert property (ms_fault_i ##1 (rd_q && reg_addr_i == 5'h0A) |=> reg_rdata_o[15])
      else $error("fault not latched");
   a_master_live: assert property (rd_q && reg_addr_i == 5'h0A && $stable(ms_master_i) && !$past(reset_i)
      |=> reg_rdata_o[14] == $past(ms_master_i, 2))
      else $error("role bit wrong");
   // Main traffic seen
   c_ext_rd: cover property (ext_rd_o);
   c_ext_wr: cover property (ext_wr_o);
   c_fast_flag: cover property (rd_q && reg_addr_i == 5'h10 ##1 reg_rdata_o[14]);
endmodule : phy_status_regs_chk
bind phy_status_regs phy_status_regs_chk chk_inst (.clock_i, .reset_i, .reg_addr_i, .reg_rd_i,
   .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .ext_device_select_o, .ext_rd_o,
   .ext_wr_o, .ext_wdata_o, .ms_master_i, .ms_fault_i);

// ### test_phy_status_mmd_window_regs.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_phy_status_mmd_window_regs;
   import phy_status_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   reg_addr_t reg_addr_i = 5'h00;
   logic reg_rd_i = 1'b0;
   logic reg_wr_i = 1'b0;
   reg_word_t reg_wdata_i = 16'h0000;
   reg_word_t reg_rdata_o, ext_addr_o, ext_wdata_o, ext_rdata_i;
   logic reg_rvalid_o, ext_rd_o, ext_wr_o;
   logic [4:0] ext_device_select_o;
   logic ms_fault_i = 1'b0, ms_master_i = 1'b1, local_rx_ok_i = 1'b0, remote_rx_ok_i = 1'b0;
   logic lp_gig_fdx_i = 1'b0, lp_gig_hdx_i = 1'b0, idle_err_i = 1'b0, mdix_err_i = 1'b0;
   logic fast_descr_lock_i = 1'b0, fast_link_i = 1'b0, gig_descr_lock_i = 1'b0;
   logic gig_link_i = 1'b0, nonstd_partner_i = 1'b0;
   logic [5:0] fast_evt_i = 6'h00;
   logic [6:0] gig_evt_i = 7'h00;
   int num_errors = 0;
   int num_checks = 0;
   phy_status_regs phy_status_regs_inst (.clock_i, .reset_i, .reg_addr_i, .reg_rd_i, .reg_wr_i,
      .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .ext_device_select_o, .ext_addr_o, .ext_rd_o,
      .ext_rdata_i, .ext_wr_o, .ext_wdata_o, .ms_fault_i, .ms_master_i, .local_rx_ok_i,
      .remote_rx_ok_i, .lp_gig_fdx_i, .lp_gig_hdx_i, .idle_err_i, .fast_descr_lock_i,
      .fast_link_i, .fast_evt_i, .gig_descr_lock_i, .gig_link_i, .gig_evt_i,
      .nonstd_partner_i, .mdix_err_i);
   phy_ext_model phy_ext_model_inst (.clock_i, .ext_addr_i(ext_addr_o), .ext_rd_i(ext_rd_o),
      .ext_wr_i(ext_wr_o), .ext_wdata_i(ext_wdata_o), .ext_rdata_o(ext_rdata_i));
   always #5 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////
   // One strobe cycle; a gap cycle keeps strobe edges apart
   task automatic wr(input reg_addr_t a, input reg_word_t d);
      @(negedge clock_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input reg_addr_t a, input reg_word_t e);
      @(negedge clock_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clock_i);
      reg_rd_i = 1'b0;
      `CHK({reg_rvalid_o, reg_rdata_o}, {1'b1, e})
   endtask : rd
   task automatic t_reset();
      rd(5'h0A, 16'h4000);
      rd(5'h0F, 16'h3000);
      rd(5'h10, 16'h0000);
      rd(5'h11, 16'h0000);
      rd(5'h05, 16'h0000);
      wr(5'h0F, 16'h0000);
      rd(5'h0F, 16'h3000);
   endtask : t_reset
   // Fault and idle errors latch until read
   task automatic t_gig_status();
      @(negedge clock_i);
      ms_master_i = 1'b0;
      local_rx_ok_i = 1'b1;
      lp_gig_fdx_i = 1'b1;
      ms_fault_i = 1'b1;
      idle_err_i = 1'b1;
      repeat (3) @(negedge clock_i);
      ms_fault_i = 1'b0;
      idle_err_i = 1'b0;
      rd(5'h0A, 16'hA803);
      rd(5'h0A, 16'h2800);
      remote_rx_ok_i = 1'b1;
      lp_gig_hdx_i = 1'b1;
      rd(5'h0A, 16'h3C00);
      // Events still up in the clearing read survive into the next read
      ms_fault_i = 1'b1;
      idle_err_i = 1'b1;
      rd(5'h0A, 16'hBC01);
      ms_fault_i = 1'b0;
      idle_err_i = 1'b0;
      rd(5'h0A, 16'hBC01);
      rd(5'h0A, 16'h3C00);
   endtask : t_gig_status
   task automatic t_fast_events();
      fast_descr_lock_i = 1'b1;
      fast_link_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(negedge clock_i);
         fast_evt_i = 6'h01 << i;
         @(negedge clock_i);
         fast_evt_i = 6'h00;
         // Bit 12 is the link level, so the two error flags sit above it
         rd(5'h10, 16'h9000 | (16'h0100 << (i < 4 ? i : i + 1)));
         rd(5'h10, 16'h9000);
      end
   endtask : t_fast_events
   task automatic t_gig_events();
      gig_descr_lock_i = 1'b1;
      gig_link_i = 1'b1;
      nonstd_partner_i = 1'b1;
      mdix_err_i = 1'b1;
      for (int i = 0; i < 7; i++) begin
         @(negedge clock_i);
         gig_evt_i = 7'h01 << i;
         @(negedge clock_i);
         gig_evt_i = 7'h00;
         // Lock error and disconnect skip over the link bit
         rd(5'h11, 16'h9060 | (16'h0080 << (i < 5 ? i : i + 1)));
         rd(5'h11, 16'h9060);
      end
   endtask : t_gig_events
   // Every function code through the window
   task automatic t_ext_window();
      wr(5'h0D, 16'h3FE5);
      rd(5'h0D, 16'h3FE5);
      `CHK(ext_device_select_o, 5'h05)
      wr(5'h0E, 16'h0004);
      rd(5'h0E, 16'h0004);
      wr(5'h0D, 16'h8005);
      wr(5'h0E, 16'hA1A1);
      wr(5'h0E, 16'hB2B2);
      wr(5'h0D, 16'h0005);
      wr(5'h0E, 16'h0004);
      wr(5'h0D, 16'h4005);
      rd(5'h0E, 16'hA1A1);
      rd(5'h0E, 16'hA1A1);
      wr(5'h0D, 16'h8005);
      rd(5'h0E, 16'hA1A1);
      rd(5'h0E, 16'hB2B2);
      wr(5'h0D, 16'hC005);
      wr(5'h0E, 16'hC3C3);
      wr(5'h0D, 16'h0005);
      rd(5'h0E, 16'h0007);
      wr(5'h0E, 16'h0006);
      wr(5'h0D, 16'hC005);
      rd(5'h0E, 16'hC3C3);
      rd(5'h0E, 16'hC3C3);
   endtask : t_ext_window
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // Hang guard
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(negedge clock_i);
      reset_i = 1'b0;
      t_reset();
      t_gig_status();
      t_fast_events();
      t_gig_events();
      t_ext_window();
      tally_and_finish();
   end
endmodule : test_phy_status_mmd_window_regs
